// ### hw/vorc_regs.sv
// Video output control register bank: register storage, status
// read-back, decoded settings and output float control.
// Assumes the serial control engine issues one-cycle read or write
// strobes with address and data, all synchronous to mclk_in.
`timescale 1ns/100ps
module vorc_regs (
  input  wire logic              mclk_in,
  input  wire logic              arst_n_in,
  input  wire logic [7:0]        reg_addr_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  input  wire logic [7:0]        reg_wdata_in,
  input  wire logic              pd_pin_in,
  input  wire logic              sync_present_in,
  input  wire vorc_pkg::vorc_link_s link_in,
  output logic [7:0]             reg_rdata_out,
  output logic                   reg_ack_out,
  output vorc_pkg::vorc_cfg_s    cfg_out,
  output vorc_pkg::vorc_pads_s   pads_out
);
  import vorc_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    vorc_bank_t bank;
    vorc_cfg_s  cfg;
    vorc_pads_s pads;
    logic [7:0] rdata;
    logic       ack;
  } vorc_state_s;

  function automatic vorc_cfg_s vorc_decode(input vorc_bank_t b);
    vorc_cfg_s c;
    logic [7:0] r0;
    logic [7:0] r2;
    logic [7:0] r3;
    logic [7:0] rc;
    logic [7:0] rd;
    logic [7:0] re;
    logic [7:0] rf;
    logic [7:0] rg;
    r0 = b[VORC_OUTPUT_ENABLE_CONTROL - VORC_OUTPUT_ENABLE_CONTROL];
    r2 = b[VORC_AUTO_SLEEP_MARKER_CONTROL - VORC_OUTPUT_ENABLE_CONTROL];
    r3 = b[VORC_FRAME_DELAY_LINE_DELAY_HI - VORC_OUTPUT_ENABLE_CONTROL];
    rc = b[VORC_GUARD_PULSE_WIDTH_LIMITS - VORC_OUTPUT_ENABLE_CONTROL];
    rd = b[VORC_GUARD_MODE_START_LINE - VORC_OUTPUT_ENABLE_CONTROL];
    re = b[VORC_GUARD_OVERRIDE_END_LINE - VORC_OUTPUT_ENABLE_CONTROL];
    rf = b[VORC_GUARD_LIMIT_CHROMA_MATRIX - VORC_OUTPUT_ENABLE_CONTROL];
    rg = b[VORC_MATRIX_RANGE_COEF_HIGH - VORC_OUTPUT_ENABLE_CONTROL];
    c.out_mode       = r0[VORC_F_OUT_MODE +: 2];
    c.marker_en      = r2[VORC_B_MARKER];
    c.force_avf      = r2[VORC_B_FORCE_AVF];
    c.interlace_ofs  = r2[2:0];
    c.frame_delay    = r3[7:2];
    c.line_delay     = {r3[1:0],
      b[VORC_LINE_DELAY_LOW - VORC_OUTPUT_ENABLE_CONTROL]};
    c.act_width      = {
      b[VORC_ACTIVE_WIDTH_HIGH - VORC_OUTPUT_ENABLE_CONTROL][3:0],
      b[VORC_ACTIVE_WIDTH_LOW - VORC_OUTPUT_ENABLE_CONTROL]};
    c.act_height     = {
      b[VORC_ACTIVE_HEIGHT_HIGH - VORC_OUTPUT_ENABLE_CONTROL][3:0],
      b[VORC_ACTIVE_HEIGHT_LOW - VORC_OUTPUT_ENABLE_CONTROL]};
    c.guard_pmax     = rc[7:4];
    c.guard_pmin     = rc[3:0];
    c.guard_oversamp = rd[VORC_B_OVERSAMP];
    c.guard_pal      = rd[VORC_B_PAL];
    c.guard_prog     = re[VORC_B_PROG];
    c.guard_override = re[VORC_B_OVERRIDE];
    c.guard_first    = rd[5:0];
    c.guard_last     = re[5:0];
    case (rf[VORC_F_PCOUNT +: 2])
      2'h0:    c.guard_pcount = VORC_PCOUNT_00;
      2'h1:    c.guard_pcount = VORC_PCOUNT_01;
      2'h2:    c.guard_pcount = VORC_PCOUNT_10;
      default: c.guard_pcount = VORC_PCOUNT_11;
    endcase
    c.up_interp      = rf[VORC_B_UP_INTERP];
    c.chroma_fir     = rf[VORC_B_CHR_FIR];
    c.matrix_en      = rf[VORC_B_MAT_EN];
    c.matrix_range   = rg[VORC_F_MAT_RANGE +: 2];
    c.coef_red_red   = {rg[4:0],
      b[VORC_MATRIX_COEF_LOW - VORC_OUTPUT_ENABLE_CONTROL]};
    return c;
  endfunction

  localparam vorc_state_s VORC_STATE_RST = '{
    bank:  VORC_RST,
    cfg:   vorc_decode(VORC_RST),
    pads:  '0,
    rdata: 8'h00,
    ack:   1'b0};

  logic        rst_meta_q;
  logic        rst_n_q;
  vorc_state_s s_q;
  vorc_state_s s_d;

  // ****************************************************************
  // Reset release
  // ****************************************************************
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [7:0] idx;
    logic       hit;
    logic [7:0] st;
    logic [7:0] pc;
    logic       rgb;
    logic       pin_act;
    logic       off;
    idx = reg_addr_in - VORC_OUTPUT_ENABLE_CONTROL;
    hit = (reg_addr_in >= VORC_OUTPUT_ENABLE_CONTROL) &&
          (reg_addr_in <= VORC_MATRIX_COEF_LOW) &&
          (reg_addr_in != VORC_GAP);
    st      = 8'h00;
    pc      = 8'h00;
    rgb     = 1'b0;
    pin_act = 1'b0;
    off     = 1'b0;
    s_d = s_q;
    // Read-only bytes are rebuilt from live inputs, never stored
    if (reg_wr_in && hit) begin
      s_d.bank[idx[4:0]] = (s_q.bank[idx[4:0]] &
                            ~VORC_WMASK[idx[4:0]]) |
                           (reg_wdata_in & VORC_WMASK[idx[4:0]]);
    end
    s_d.ack   = (reg_wr_in || reg_rd_in) && hit;
    s_d.rdata = 8'h00;
    if (reg_rd_in && hit) begin
      if (reg_addr_in == VORC_LINK_STATUS) begin
        s_d.rdata = {1'b0, link_in.link_bits};
      end else if (reg_addr_in == VORC_LINK_SYNC_POLARITY_STATUS) begin
        s_d.rdata = {2'b00, link_in.sync_pol, 4'h0};
      end else begin
        s_d.rdata = s_q.bank[idx[4:0]];
      end
    end
    s_d.cfg = vorc_decode(s_d.bank);

    // Float control follows the bank as it stands after this edge
    st  = s_d.bank[VORC_THREE_STATE_POWER_CONTROL -
                   VORC_OUTPUT_ENABLE_CONTROL];
    pc  = s_d.bank[VORC_AUTO_SLEEP_MARKER_CONTROL -
                   VORC_OUTPUT_ENABLE_CONTROL];
    rgb = (s_d.cfg.out_mode != VORC_MODE_YC422) &&
          (s_d.cfg.out_mode != VORC_MODE_DDR444);
    pin_act = (pd_pin_in == st[VORC_B_PD_POL]);
    off = st[VORC_B_ALL_TRI] || st[VORC_B_PD] || pin_act;
    s_d.pads.rg_oe = !off && (rgb ||
      s_d.bank[0][VORC_B_PRIM_EN]);
    s_d.pads.b_oe = !off && (rgb ||
      s_d.bank[0][VORC_B_SEC_EN]);
    s_d.pads.sync_clk_oe = !off;
    s_d.pads.sog_oe = !st[VORC_B_SOG_TRI] &&
      !(pin_act && st[VORC_F_PD_FUNC]);
    s_d.pads.seek = pc[VORC_B_AUTO_SLP] && !sync_present_in;
    s_d.pads.sleep = st[VORC_B_PD] || s_d.pads.seek ||
      (pin_act && !st[VORC_F_PD_FUNC + 1]);
  end

  always_ff @(posedge mclk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s_q <= VORC_STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata_out = s_q.rdata;
  assign reg_ack_out   = s_q.ack;
  assign cfg_out       = s_q.cfg;
  assign pads_out      = s_q.pads;

endmodule

// ### hw/vorc_pkg.sv
// Constants, register map and carrier types of the video output
// control register bank. Assumes a byte-wide register port fed by
// the chip's serial control engine.
//
// ****************************************************************
// Summary of operation
// ****************************************************************
// Summary of operation
// - Red/green drive when primary enable set
// - Blue drives when secondary enable set
// - Three-state bits float outputs or sync-on-green
// - Polarity bit sets power-down pin active level
// - Pin function selects sleep and float scope
// - Power-down bit floats syncs, clock, data
// - Auto sleep enters seek without syncs
// - Marker enable inserts active video codes
// - Force bit generates active video flag
// - Three-bit interlace offset in line syncs
// - Six-bit frame delay, reset 24 lines
// - Ten-bit line delay, reset 0x104
// - Active width 0x500, height 0x2D0
// - Read-only link presence and key bits
// - Read-only sync polarities
// - Guard pulse width limits nine and six
// - Guard mode bits and preset override
// - Guard window lines 13 to 21
// - Pulse count codes map 6,4,5,7
// - Matrix enable and range field
// - Thirteen-bit coefficient, reset 0x0C52
// - Chroma repeat/interpolate and filter bits
// - Output mode codes 00, 01, 10
package vorc_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] VORC_OUTPUT_ENABLE_CONTROL    = 8'h25;
  localparam logic [7:0] VORC_THREE_STATE_POWER_CONTROL = 8'h26;
  localparam logic [7:0] VORC_AUTO_SLEEP_MARKER_CONTROL = 8'h27;
  localparam logic [7:0] VORC_FRAME_DELAY_LINE_DELAY_HI = 8'h28;
  localparam logic [7:0] VORC_LINE_DELAY_LOW           = 8'h29;
  localparam logic [7:0] VORC_ACTIVE_WIDTH_HIGH        = 8'h2A;
  localparam logic [7:0] VORC_ACTIVE_WIDTH_LOW         = 8'h2B;
  localparam logic [7:0] VORC_ACTIVE_HEIGHT_HIGH       = 8'h2C;
  localparam logic [7:0] VORC_ACTIVE_HEIGHT_LOW        = 8'h2D;
  localparam logic [7:0] VORC_GAP                      = 8'h2E;
  localparam logic [7:0] VORC_LINK_STATUS              = 8'h2F;
  localparam logic [7:0] VORC_LINK_SYNC_POLARITY_STATUS = 8'h30;
  localparam logic [7:0] VORC_GUARD_PULSE_WIDTH_LIMITS = 8'h31;
  localparam logic [7:0] VORC_GUARD_MODE_START_LINE    = 8'h32;
  localparam logic [7:0] VORC_GUARD_OVERRIDE_END_LINE  = 8'h33;
  localparam logic [7:0] VORC_GUARD_LIMIT_CHROMA_MATRIX = 8'h34;
  localparam logic [7:0] VORC_MATRIX_RANGE_COEF_HIGH   = 8'h35;
  localparam logic [7:0] VORC_MATRIX_COEF_LOW          = 8'h36;

  localparam int VORC_NREG = 18;
  typedef logic [VORC_NREG-1:0][7:0] vorc_bank_t;

  // Reset values and writable bits, index 0 is offset 0x25
  localparam vorc_bank_t VORC_RST = {
    8'h52, 8'h2C, 8'h80, 8'h15, 8'h0D, 8'h96,
    8'h00, 8'h00, 8'h00, 8'hD0, 8'h02, 8'h00,
    8'h05, 8'h04, 8'h61, 8'h80, 8'h08, 8'h72};
  localparam vorc_bank_t VORC_WMASK = {
    8'hFF, 8'h7F, 8'hFE, 8'hFF, 8'hFF, 8'hFF,
    8'h00, 8'h00, 8'h00, 8'hFF, 8'h0F, 8'hFF,
    8'h0F, 8'hFF, 8'hFF, 8'hDF, 8'hCF, 8'hFF};

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int VORC_B_PRIM_EN   = 1;
  localparam int VORC_B_SEC_EN    = 0;
  localparam int VORC_F_OUT_MODE  = 2;
  localparam int VORC_B_ALL_TRI   = 7;
  localparam int VORC_B_SOG_TRI   = 6;
  localparam int VORC_B_PD_POL    = 3;
  localparam int VORC_F_PD_FUNC   = 1;
  localparam int VORC_B_PD        = 0;
  localparam int VORC_B_AUTO_SLP  = 7;
  localparam int VORC_B_MARKER    = 4;
  localparam int VORC_B_FORCE_AVF = 3;
  localparam int VORC_B_OVERSAMP  = 7;
  localparam int VORC_B_PAL       = 6;
  localparam int VORC_B_PROG      = 7;
  localparam int VORC_B_OVERRIDE  = 6;
  localparam int VORC_F_PCOUNT    = 6;
  localparam int VORC_B_UP_INTERP = 3;
  localparam int VORC_B_CHR_FIR   = 2;
  localparam int VORC_B_MAT_EN    = 1;
  localparam int VORC_F_MAT_RANGE = 5;

  // ****************************************************************
  // Encodings
  // ****************************************************************
  localparam logic [1:0] VORC_MODE_RGB444 = 2'h0;
  localparam logic [1:0] VORC_MODE_YC422  = 2'h1;
  localparam logic [1:0] VORC_MODE_DDR444 = 2'h2;
  localparam logic [2:0] VORC_PCOUNT_00   = 3'h6;
  localparam logic [2:0] VORC_PCOUNT_01   = 3'h4;
  localparam logic [2:0] VORC_PCOUNT_10   = 3'h5;
  localparam logic [2:0] VORC_PCOUNT_11   = 3'h7;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [1:0]  out_mode;
    logic        marker_en;
    logic        force_avf;
    logic [2:0]  interlace_ofs;
    logic [5:0]  frame_delay;
    logic [9:0]  line_delay;
    logic [11:0] act_width;
    logic [11:0] act_height;
    logic [3:0]  guard_pmax;
    logic [3:0]  guard_pmin;
    logic        guard_oversamp;
    logic        guard_pal;
    logic        guard_prog;
    logic        guard_override;
    logic [5:0]  guard_first;
    logic [5:0]  guard_last;
    logic [2:0]  guard_pcount;
    logic        up_interp;
    logic        chroma_fir;
    logic        matrix_en;
    logic [1:0]  matrix_range;
    logic [12:0] coef_red_red;
  } vorc_cfg_s;

  typedef struct packed {
    logic [6:0] link_bits;
    logic [1:0] sync_pol;
  } vorc_link_s;

  typedef struct packed {
    logic rg_oe;
    logic b_oe;
    logic sync_clk_oe;
    logic sog_oe;
    logic sleep;
    logic seek;
  } vorc_pads_s;

endpackage

// ### testbench/vorc_regs_asserts.sv
// Checker for the register port and pad enables of vorc_regs.
// Assumes it is bound onto vorc_regs and sees only its ports.
`timescale 1ns/100ps
module vorc_regs_asserts (
  input wire logic                 mclk_in,
  input wire logic                 arst_n_in,
  input wire logic [7:0]           reg_addr_in,
  input wire logic                 reg_wr_in,
  input wire logic                 reg_rd_in,
  input wire logic [7:0]           reg_wdata_in,
  input wire logic                 pd_pin_in,
  input wire logic                 sync_present_in,
  input wire vorc_pkg::vorc_link_s link_in,
  input wire logic [7:0]           reg_rdata_out,
  input wire logic                 reg_ack_out,
  input wire vorc_pkg::vorc_cfg_s  cfg_out,
  input wire vorc_pkg::vorc_pads_s pads_out
);
  import vorc_pkg::*;
  // ********
  // Helpers
  // ********
  logic map_a, stb, w25, w26;
  assign map_a = reg_addr_in >= 8'h25 && reg_addr_in <= 8'h36
                 && reg_addr_in != 8'h2E;
  assign stb = reg_wr_in || reg_rd_in;
  assign w25 = reg_wr_in && reg_addr_in == 8'h25;
  assign w26 = reg_wr_in && reg_addr_in == 8'h26;
  function automatic logic [2:0] pc_map(input logic [1:0] c);
    return c == 2'h0 ? 3'h6 : c == 2'h1 ? 3'h4 : c == 2'h2 ? 3'h5 : 3'h7;
  endfunction
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!arst_n_in);
  // ********
  // Properties
  // ********
  a_ack_mapped: assert property (stb && map_a |=> reg_ack_out)
    else $error("missing ack");
  a_no_stray_ack: assert property (!(stb && map_a) |=> !reg_ack_out)
    else $error("ack without mapped strobe");
  a_rdata_idle: assert property (!(reg_rd_in && map_a) |=>
    reg_rdata_out == 8'h00) else $error("read data not zero");
  a_global_tri: assert property (w26 && reg_wdata_in[7] |=>
    !pads_out.rg_oe && !pads_out.b_oe && !pads_out.sync_clk_oe)
    else $error("outputs not floated");
  a_sog_tri: assert property (w26 && reg_wdata_in[6] |=>
    !pads_out.sog_oe) else $error("sync on green not floated");
  a_pd_float: assert property (w26 && reg_wdata_in[0] |=>
    pads_out.sleep && !pads_out.sync_clk_oe)
    else $error("power down not taken");
  a_prim_off: assert property (w25 && reg_wdata_in[3:2] == 2'h1
    && !reg_wdata_in[1] |=> !pads_out.rg_oe) else $error("primary on");
  a_sec_off: assert property (w25 && reg_wdata_in[3:2] == 2'h2
    && !reg_wdata_in[0] |=> !pads_out.b_oe) else $error("secondary on");
  a_width_low: assert property (reg_wr_in && reg_addr_in == 8'h2B |=>
    cfg_out.act_width[7:0] == $past(reg_wdata_in))
    else $error("width low byte wrong");
  a_status_read: assert property (reg_rd_in && !reg_wr_in
    && reg_addr_in == 8'h2F |=> reg_rdata_out ==
    {1'b0, $past(link_in.link_bits)}) else $error("status wrong");
  a_pcount_map: assert property (reg_wr_in && reg_addr_in == 8'h34 |=>
    cfg_out.guard_pcount == pc_map($past(reg_wdata_in[7:6])))
    else $error("pulse count wrong");
  c_tri: cover property (w26 && reg_wdata_in[7]);
  c_status: cover property (reg_rd_in && reg_addr_in == 8'h2F);
  c_refused: cover property (stb && !map_a);
endmodule

bind vorc_regs vorc_regs_asserts u_chk (.mclk_in, .arst_n_in,
  .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in, .pd_pin_in,
  .sync_present_in, .link_in, .reg_rdata_out, .reg_ack_out, .cfg_out,
  .pads_out);

// ### testbench/video_output_control_regs_tb_top.sv
// Self-checking bench for the video output control register bank.
// Assumes vorc_regs with its checker bound to it.
`timescale 1ns/100ps
module video_output_control_regs_tb_top;
  import vorc_pkg::*;
  logic        mclk_in = 0, arst_n_in = 0, reg_wr_in = 0, reg_rd_in = 0;
  logic        pd_pin_in = 0, sync_present_in = 1, reg_ack_out;
  logic [7:0]  reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
  vorc_link_s  link_in = '0;
  vorc_cfg_s   cfg_out;
  vorc_pads_s  pads_out;
  int          fail_count = 0, tests_run = 0, cyc = 0;
  logic [31:0] lf = 32'hBCC1;
  logic [7:0]  sh [8'h25:8'h36];
  logic [7:0]  q [$];
  logic [2:0]  pc [4] = '{3'h6, 3'h4, 3'h5, 3'h7};
  always #10 mclk_in = ~mclk_in;
  vorc_regs u_dut (.mclk_in, .arst_n_in, .reg_addr_in, .reg_wr_in,
    .reg_rd_in, .reg_wdata_in, .pd_pin_in, .sync_present_in, .link_in,
    .reg_rdata_out, .reg_ack_out, .cfg_out, .pads_out);
  // ********
  // Tasks
  // ********
  task automatic chk(input logic [15:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("compares %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Strobes stay up so back-to-back accesses need no idle cycle
  task automatic acc(input logic w, input logic [7:0] a, d);
    reg_wr_in = w;
    reg_rd_in = !w;
    reg_addr_in = a;
    reg_wdata_in = d;
    if (a >= 8'h25 && a <= 8'h36 && a != 8'h2E) begin
      q.push_back(w ? 8'h00 : a == 8'h2F ? {1'b0, link_in.link_bits} :
        a == 8'h30 ? {2'h0, link_in.sync_pol, 4'h0} : sh[a]);
      if (w && a != 8'h2F && a != 8'h30) sh[a] = d & VORC_WMASK[a-8'h25];
    end
    @(posedge mclk_in);
    #1;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic idle(input int n);
    reg_wr_in = 0;
    reg_rd_in = 0;
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  function automatic logic [5:0] pexp(input logic [7:0] r5, r6,
                                      input logic pin);
    logic act, fl, dm;
    act = pin == r6[3];
    fl = r6[7] | r6[0] | act;
    dm = r5[3:2] == 2'h1 || r5[3:2] == 2'h2;
    return {!fl & (!dm | r5[1]), !fl & (!dm | r5[0]), !fl,
            !r6[6] & !(act & r6[1]), r6[0] | (act & !r6[2]), 1'b0};
  endfunction
  // ********
  // Checking
  // ********
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      finish_test();
    end
    if (reg_ack_out === 1'b1) begin
      if (q.size() == 0) chk(16'h1, 16'h0);
      else chk(reg_rdata_out, q.pop_front());
    end
  end
  initial begin
    for (int i = 0; i < 18; i++) sh[8'h25+i] = VORC_RST[i] & VORC_WMASK[i];
    repeat (4) @(posedge mclk_in);
    #1;
    arst_n_in = 1;
    idle(4);
    chk(cfg_out.act_width, 16'h0500);
    chk(cfg_out.act_height, 16'h02D0);
    chk(cfg_out.line_delay, 16'h0104);
    chk(cfg_out.frame_delay, 16'h0018);
    chk({cfg_out.guard_pmax, cfg_out.guard_pmin}, 16'h0096);
    chk({cfg_out.guard_first, cfg_out.guard_last}, 16'h0355);
    chk(cfg_out.guard_pcount, 16'h0005);
    chk({cfg_out.matrix_en, cfg_out.matrix_range}, 16'h0001);
    chk(cfg_out.coef_red_red, 16'h0C52);
    chk({cfg_out.out_mode, cfg_out.marker_en, cfg_out.force_avf,
         cfg_out.interlace_ofs}, 16'h0000);
    chk(pads_out, 16'h003C);
    $display("test reset values done");
    link_in = lf[8:0];
    for (int a = 8'h24; a <= 8'h37; a++) acc(0, a[7:0], 8'h00);
    idle(3);
    chk(q.size(), 16'h0);
    $display("test reset read back done");
    for (int a = 8'h24; a <= 8'h37; a++) begin
      lf = lfsr(lf);
      acc(1, a[7:0], lf[7:0]);
      acc(0, a[7:0], 8'h00);
    end
    idle(3);
    chk(q.size(), 16'h0);
    chk({cfg_out.up_interp, cfg_out.chroma_fir, cfg_out.marker_en,
         cfg_out.force_avf, cfg_out.interlace_ofs},
        {sh[8'h34][3:2], sh[8'h27][4:0]});
    chk(cfg_out.line_delay, {sh[8'h28][1:0], sh[8'h29]});
    chk({cfg_out.guard_oversamp, cfg_out.guard_pal, cfg_out.guard_prog,
         cfg_out.guard_override}, {sh[8'h32][7:6], sh[8'h33][7:6]});
    chk(cfg_out.coef_red_red, {sh[8'h35][4:0], sh[8'h36]});
    $display("test write read back done");
    for (int k = 0; k < 4; k++) begin
      acc(1, 8'h34, {k[1:0], 6'h00});
      acc(1, 8'h35, {1'b0, k[1:0], 5'h00});
      idle(1);
      chk(cfg_out.guard_pcount, pc[k]);
      chk(cfg_out.matrix_range, k[1:0]);
    end
    $display("test code tables done");
    repeat (40) begin
      lf = lfsr(lf);
      pd_pin_in = lf[12];
      acc(1, 8'h25, {4'h7, lf[3:0]});
      acc(1, 8'h26, {lf[7:6], 2'h0, lf[11:8]});
      idle(3);
      chk(pads_out, pexp(sh[8'h25], sh[8'h26], pd_pin_in));
    end
    $display("test output enables done");
    pd_pin_in = 0;
    acc(1, 8'h26, 8'h08);
    acc(1, 8'h27, 8'h80);
    sync_present_in = 0;
    idle(3);
    chk({pads_out.seek, pads_out.sleep}, 16'h0003);
    acc(1, 8'h27, 8'h00);
    idle(3);
    chk({pads_out.seek, pads_out.sleep}, 16'h0000);
    sync_present_in = 1;
    $display("test auto sleep done");
    // Mid-run reset: let the last ack drain before pulling reset
    acc(1, 8'h29, 8'h00);
    idle(1);
    arst_n_in = 0;
    idle(2);
    chk({pads_out, reg_ack_out}, 16'h0000);
    arst_n_in = 1;
    idle(4);
    chk(cfg_out.line_delay, 16'h0104);
    chk(pads_out, 16'h003C);
    $display("test mid-run reset done");
    finish_test();
  end
endmodule
